// >>> hw/pcm_pwm.sv
// peak-current-mode pwm: timer, compare units, blanking, slope dac
// Notes on behaviour
// - counter counts up, wraps at period 27200
// - compare one at 21760 clears high side
// - compare two steps the sawtooth, rewritable
// - compare three ends trip blanking window
// - compare four at 1088 sets high side
// - low side complements high with dead time
// - comparator trip forces output inactive
// - sawtooth starts 4000, falls by 66
// - sawtooth reloads on wrap, steps on compare
// - comparator enters timer as external event three
// - period and compare writes act immediately
// - compare event when counter equals value
// - event three blanked from wrap to compare three
// - first of compare one or trip clears
// - dead time 75 rising, 200 falling ticks
// - fault forces output inactive
`timescale 1ns/1ps
module pcm_pwm import pcm_pkg::*; #(
   parameter int CW = PCM_CNT_W,
   parameter int DW = 16,
   parameter int AW = 4,
   parameter int DACW = PCM_DAC_W
) (
   // clock, reset and enable
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic ce,
   // register port
   input wire logic [AW-1:0] reg_addr,
   input wire logic [DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DW-1:0] reg_rdata,
   // analogue side inputs, asynchronous
   input wire logic peak_current_comparator,
   input wire logic fault_pin,
   // power stage drives
   output pcm_drive_s drive,
   output logic [DACW-1:0] slope_threshold_dac,
   output logic boost_high_switch_pin,
   output logic boost_low_switch_pin
);
   // register state
   logic run;
   logic [CW-1:0] period;
   logic [CW-1:0] cmp_val [4];
   logic [DACW-1:0] dac_reset_val;
   logic [DACW-1:0] dac_step_val;
   // timer state
   logic [CW-1:0] cnt;
   logic wrap;
   logic [3:0] evt;
   logic blank;
   logic hs_ref;
   logic trip_seen;
   // synchronisers
   logic trip_s1;
   logic trip_s2;
   logic fault_s1;
   logic fault_s2;
   // derived events
   logic ext_evt3;
   logic clear_any;
   logic set_any;
   logic [DW-1:0] next_rdata;
   pcm_status_s status;

   // write decode, shared by every register
   function automatic logic wr_hit(input logic wr, input logic [AW-1:0] a,
                                   input int off);
      return wr && (a == AW'(off));
   endfunction : wr_hit

   // equality compare used by all four compare units
   function automatic logic cmp_match(input logic [CW-1:0] c,
                                      input logic [CW-1:0] v);
      return c == v;
   endfunction : cmp_match

   // two flops before anything reads the asynchronous pins
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         trip_s1 <= 1'b0;
         trip_s2 <= 1'b0;
         fault_s1 <= 1'b0;
         fault_s2 <= 1'b0;
      end else if (ce) begin
         trip_s1 <= peak_current_comparator;
         trip_s2 <= trip_s1;
         fault_s1 <= fault_pin;
         fault_s2 <= fault_s1;
      end
   end

   // control register: run and the static boost switch levels
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         run <= 1'b0;
         boost_high_switch_pin <= 1'b0;
         boost_low_switch_pin <= 1'b0;
      end else if (ce && wr_hit(reg_wr, reg_addr, PCM_OFF_CTRL)) begin
         run <= reg_wdata[PCM_CTRL_RUN];
         // levels are whatever firmware writes; it keeps them static
         boost_high_switch_pin <= reg_wdata[PCM_CTRL_BOOST_HI];
         boost_low_switch_pin <= reg_wdata[PCM_CTRL_BOOST_LO];
      end
   end

   // period and sawtooth values: no preload, writes land in the live copy
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         period <= PCM_PERIOD_RST;
      end else if (ce && wr_hit(reg_wr, reg_addr, PCM_OFF_PERIOD)) begin
         period <= reg_wdata[CW-1:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         dac_reset_val <= PCM_DAC_RST_RST;
         dac_step_val <= PCM_DAC_STEP_RST;
      end else if (ce) begin
         if (wr_hit(reg_wr, reg_addr, PCM_OFF_DAC_RST)) begin
            dac_reset_val <= reg_wdata[DACW-1:0];
         end
         if (wr_hit(reg_wr, reg_addr, PCM_OFF_DAC_STEP)) begin
            dac_step_val <= reg_wdata[DACW-1:0];
         end
      end
   end

   // four compare units, each a live register and an equality event
   for (genvar i = 0; i < 4; i++) begin : g_cmp
      always_ff @(posedge clk_sys) begin
         if (srst) begin
            cmp_val[i] <= PCM_CMP_RST[i];
         end else if (ce && wr_hit(reg_wr, reg_addr, PCM_OFF_CMP1 + i)) begin
            cmp_val[i] <= reg_wdata[CW-1:0];
         end
      end
      assign evt[i] = run && cmp_match(cnt, cmp_val[i]);
   end

   // up counter; >= so a period lowered below the count still wraps
   assign wrap = run && (cnt >= period);

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         cnt <= '0;
      end else if (ce) begin
         if (!run || wrap) begin
            cnt <= '0;
         end else begin
            cnt <= cnt + 1'b1;
         end
      end
   end

   // blanking window from wrap until compare three; held while stopped
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         blank <= 1'b1;
      end else if (ce) begin
         if (!run || wrap) begin
            blank <= 1'b1;
         end else if (evt[2]) begin
            blank <= 1'b0;
         end
      end
   end

   // comparator as filtered external event three
   assign ext_evt3 = trip_s2 && !blank;

   // reset sources: max duty, peak trip, fault, or stopped
   assign clear_any = evt[0] || ext_evt3 || fault_s2 || !run;
   assign set_any = evt[3];

   // output latch; clear is tested first so it wins a tie
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         hs_ref <= 1'b0;
      end else if (ce) begin
         if (clear_any) begin
            hs_ref <= 1'b0;
         end else if (set_any) begin
            hs_ref <= 1'b1;
         end
      end
   end

   // sticky record of a peak trip; a new trip beats a write-one clear
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         trip_seen <= 1'b0;
      end else if (ce) begin
         if (ext_evt3) begin
            trip_seen <= 1'b1;
         end else if (wr_hit(reg_wr, reg_addr, PCM_OFF_STATUS) &&
                      reg_wdata[PCM_STAT_TRIP_SEEN]) begin
            trip_seen <= 1'b0;
         end
      end
   end

   // dead time pair on the high side reference
   pcm_deadtime #(
      .DTW(PCM_DT_W)
   ) u_deadtime (
      .clk_sys(clk_sys),
      .srst(srst),
      .ce(ce),
      .ref_in(hs_ref),
      .dt_rise(PCM_DT_RISE),
      .dt_fall(PCM_DT_FALL),
      .drive(drive)
   );

   // sawtooth: reloads on wrap (and while stopped), steps on compare two
   pcm_sawtooth #(
      .DW(DACW)
   ) u_sawtooth (
      .clk_sys(clk_sys),
      .srst(srst),
      .ce(ce),
      .rst_trig(wrap || !run),
      .step_trig(evt[1]),
      .reset_val(dac_reset_val),
      .step_val(dac_step_val),
      .value(slope_threshold_dac)
   );

   // status word
   assign status = '{trip_seen: trip_seen, fault: fault_s2, trip: trip_s2,
                     blank: blank, ls: drive.ls, hs: drive.hs};

   // read mux; unmapped words read zero
   always_comb begin
      next_rdata = '0;
      unique case (reg_addr)
         AW'(PCM_OFF_CTRL): begin
            next_rdata[PCM_CTRL_RUN] = run;
            next_rdata[PCM_CTRL_BOOST_HI] = boost_high_switch_pin;
            next_rdata[PCM_CTRL_BOOST_LO] = boost_low_switch_pin;
         end
         AW'(PCM_OFF_PERIOD): next_rdata[CW-1:0] = period;
         AW'(PCM_OFF_CMP1): next_rdata[CW-1:0] = cmp_val[0];
         AW'(PCM_OFF_CMP1 + 1): next_rdata[CW-1:0] = cmp_val[1];
         AW'(PCM_OFF_CMP1 + 2): next_rdata[CW-1:0] = cmp_val[2];
         AW'(PCM_OFF_CMP1 + 3): next_rdata[CW-1:0] = cmp_val[3];
         AW'(PCM_OFF_DAC_RST): next_rdata[DACW-1:0] = dac_reset_val;
         AW'(PCM_OFF_DAC_STEP): next_rdata[DACW-1:0] = dac_step_val;
         AW'(PCM_OFF_STATUS): next_rdata[$bits(status)-1:0] = status;
         AW'(PCM_OFF_COUNT): next_rdata[CW-1:0] = cnt;
         AW'(PCM_OFF_DAC_VAL): next_rdata[DACW-1:0] = slope_threshold_dac;
         default: next_rdata = '0;
      endcase
   end

   // read data stand for one cycle only, zero otherwise
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         reg_rdata <= '0;
      end else if (ce) begin
         reg_rdata <= reg_rd ? next_rdata : '0;
      end
   end

   // checks on the timer and output logic
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);

   property p_wrap;
      (ce && wrap) |=> cnt == '0;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("counter did not wrap at period");

   property p_count_up;
      (ce && run && !wrap) |=> cnt == $past(cnt) + 1'b1;
   endproperty
   a_count_up: assert property (p_count_up)
      else $error("counter did not advance");

   property p_max_duty;
      (ce && run && cnt == cmp_val[0]) |=> !hs_ref;
   endproperty
   a_max_duty: assert property (p_max_duty)
      else $error("compare one did not clear output");

   property p_set;
      (ce && run && cnt == cmp_val[3] && !clear_any) |=> hs_ref;
   endproperty
   a_set: assert property (p_set)
      else $error("compare four did not set output");

   property p_trip_clears;
      (ce && run && trip_s2 && !blank) |=> !hs_ref;
   endproperty
   a_trip_clears: assert property (p_trip_clears)
      else $error("peak trip did not clear output");

   property p_blanked;
      (ce && run && hs_ref && blank && !evt[0] && !fault_s2) |=> hs_ref;
   endproperty
   a_blanked: assert property (p_blanked)
      else $error("trip inside blanking window acted");

   property p_blank_end;
      (ce && run && !wrap && cnt == cmp_val[2]) |=> !blank;
   endproperty
   a_blank_end: assert property (p_blank_end)
      else $error("blanking did not end at compare three");

   property p_fault;
      (ce && fault_s2) |=> !hs_ref ##2 !drive.hs;
   endproperty
   a_fault: assert property (p_fault)
      else $error("fault did not force output inactive");

   property p_clear_wins;
      (ce && evt[3] && clear_any) |=> !hs_ref;
   endproperty
   a_clear_wins: assert property (p_clear_wins)
      else $error("set beat a coincident clear");

   property p_live_write;
      (ce && reg_wr && reg_addr == AW'(PCM_OFF_CMP1 + 1))
         |=> cmp_val[1] == $past(reg_wdata[CW-1:0]);
   endproperty
   a_live_write: assert property (p_live_write)
      else $error("compare write not taken at once");

   property p_dac_step;
      (ce && evt[1] && !wrap)
         |=> slope_threshold_dac <= $past(slope_threshold_dac);
   endproperty
   a_dac_step: assert property (p_dac_step)
      else $error("sawtooth rose on a step");

   // main scenarios
   c_wrap: cover property (ce && wrap);
   c_trip_clear: cover property (ce && hs_ref ##1 ext_evt3 ##1 !hs_ref);
   c_max_duty: cover property (ce && hs_ref && evt[0] ##1 !hs_ref);
   c_blanked_trip: cover property (ce && run && trip_s2 && blank);
endmodule : pcm_pwm

// >>> hw/pcm_pkg.sv
// shared constants and carrier types for the peak-current-mode pwm block
package pcm_pkg;
   // widths
   localparam int PCM_CNT_W = 16;
   localparam int PCM_DAC_W = 12;
   localparam int PCM_DT_W = 8;
   // timer values after reset, in timer ticks (one tick per clk_sys)
   localparam logic [15:0] PCM_PERIOD_RST = 16'h6A40;   // 27200
   localparam logic [15:0] PCM_CMP1_RST = 16'h5500;     // 21760, max duty
   localparam logic [15:0] PCM_CMP2_RST = 16'h03E8;     // 1000, slope step
   localparam logic [15:0] PCM_CMP3_RST = 16'h0AA0;     // 2720, blank end
   localparam logic [15:0] PCM_CMP4_RST = 16'h0440;     // 1088, output set
   localparam logic [15:0] PCM_CMP_RST [4] = '{PCM_CMP1_RST, PCM_CMP2_RST,
                                               PCM_CMP3_RST, PCM_CMP4_RST};
   // sawtooth threshold values after reset
   localparam logic [11:0] PCM_DAC_RST_RST = 12'hFA0;   // 4000
   localparam logic [11:0] PCM_DAC_STEP_RST = 12'h042;  // 66
   // dead time in ticks
   localparam logic [7:0] PCM_DT_RISE = 8'h4B;          // 75
   localparam logic [7:0] PCM_DT_FALL = 8'hC8;          // 200
   // external event slot that carries the comparator
   localparam int PCM_PEAK_EVT = 3;
   // register word offsets
   localparam int PCM_OFF_CTRL = 0;
   localparam int PCM_OFF_PERIOD = 1;
   localparam int PCM_OFF_CMP1 = 2;     // cmp2..cmp4 follow at 3..5
   localparam int PCM_OFF_DAC_RST = 6;
   localparam int PCM_OFF_DAC_STEP = 7;
   localparam int PCM_OFF_STATUS = 8;
   localparam int PCM_OFF_COUNT = 9;
   localparam int PCM_OFF_DAC_VAL = 10;
   // control and status bit positions
   localparam int PCM_CTRL_RUN = 0;
   localparam int PCM_CTRL_BOOST_HI = 1;
   localparam int PCM_CTRL_BOOST_LO = 2;
   localparam int PCM_STAT_TRIP_SEEN = 5;
   // gate drive pair
   typedef struct packed {
      logic hs;
      logic ls;
   } pcm_drive_s;
   // status word, low bits of the status register
   typedef struct packed {
      logic trip_seen;
      logic fault;
      logic trip;
      logic blank;
      logic ls;
      logic hs;
   } pcm_status_s;
endpackage : pcm_pkg

// >>> hw/pcm_sawtooth.sv
// decrementing sawtooth code for the slope threshold dac
`timescale 1ns/1ps
module pcm_sawtooth import pcm_pkg::*; #(
   parameter int DW = PCM_DAC_W
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic ce,
   // triggers from the timer
   input wire logic rst_trig,
   input wire logic step_trig,
   // software values
   input wire logic [DW-1:0] reset_val,
   input wire logic [DW-1:0] step_val,
   // dac code
   output logic [DW-1:0] value
);
   // reset trigger wins over a step; the ramp floors at zero rather than wrap
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         value <= PCM_DAC_RST_RST;
      end else if (ce) begin
         if (rst_trig) begin
            value <= reset_val;
         end else if (step_trig) begin
            value <= (value > step_val) ? value - step_val : '0;
         end
      end
   end

   property p_saw_reload;
      @(posedge clk_sys) disable iff (srst)
      (ce && rst_trig) |=> value == $past(reset_val);
   endproperty
   a_saw_reload: assert property (p_saw_reload)
      else $error("sawtooth did not reload");

   property p_saw_step;
      @(posedge clk_sys) disable iff (srst)
      (ce && step_trig && !rst_trig && value > step_val)
         |=> value == $past(value) - $past(step_val);
   endproperty
   a_saw_step: assert property (p_saw_step)
      else $error("sawtooth step wrong");
endmodule : pcm_sawtooth

// >>> hw/pcm_deadtime.sv
// complementary gate pair with separate rising and falling dead time
`timescale 1ns/1ps
module pcm_deadtime import pcm_pkg::*; #(
   parameter int DTW = PCM_DT_W
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic ce,
   // reference and dead times in ticks
   input wire logic ref_in,
   input wire logic [DTW-1:0] dt_rise,
   input wire logic [DTW-1:0] dt_fall,
   // gate drives
   output pcm_drive_s drive
);
   logic ref_q;
   logic [DTW-1:0] cnt;

   // count ticks since the last reference edge, saturating
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ref_q <= 1'b0;
         cnt <= '0;
      end else if (ce) begin
         if (ref_in != ref_q) begin
            ref_q <= ref_in;
            cnt <= '0;
         end else if (cnt != '1) begin
            cnt <= cnt + 1'b1;
         end
      end
   end

   // each side turns on only after its dead time, off at once
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         drive <= '0;
      end else if (ce) begin
         drive.hs <= ref_q && ref_in && cnt >= dt_rise;
         drive.ls <= !ref_q && !ref_in && cnt >= dt_fall;
      end
   end

   property p_no_overlap;
      @(posedge clk_sys) disable iff (srst)
      !(drive.hs && drive.ls);
   endproperty
   a_no_overlap: assert property (p_no_overlap)
      else $error("both switches driven");

   property p_rise_dt;
      @(posedge clk_sys) disable iff (srst)
      $rose(drive.hs) |-> $past(ref_q) && $past(cnt) >= $past(dt_rise);
   endproperty
   a_rise_dt: assert property (p_rise_dt)
      else $error("high side rose before dead time");

   property p_fall_dt;
      @(posedge clk_sys) disable iff (srst)
      $rose(drive.ls) |-> !$past(ref_q) && $past(cnt) >= $past(dt_fall);
   endproperty
   a_fall_dt: assert property (p_fall_dt)
      else $error("low side rose before dead time");
endmodule : pcm_deadtime

// >>> tb/pcm_plant.sv
// behavioural buck stage: inductor current ramp and peak comparator
`timescale 1ns/1ps
module pcm_plant import pcm_pkg::*; (
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // bench controls
   input wire logic load_on,
   input wire logic force_trip,
   // from the block
   input wire pcm_drive_s drive,
   input wire logic [PCM_DAC_W-1:0] dac,
   // comparator back to the block
   output logic cmp_out
);
   int cur;
   // current climbs 16 a tick with the high side on and decays otherwise;
   // the low phase is long enough that every cycle with load_on set starts from zero current
   always @(posedge clk_sys) begin
      if (srst)
         cur <= 0;
      else if (drive.hs === 1'b1)
         cur <= cur + 16;
      else
         cur <= (cur > 16) ? cur - 16 : 0;
   end
   // sensed current on plus input, threshold on minus input
   assign cmp_out = force_trip | (load_on & (cur >= int'(dac)));
endmodule : pcm_plant

// >>> tb/tb_top.sv
// self-checking bench for the peak-current-mode pwm block
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
   $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_top import pcm_pkg::*; ();
   logic clk_sys, srst, ce, reg_wr, reg_rd, trip_in, fault_pin;
   logic load_on, force_trip, bhi, blo;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, rd_val;
   logic [11:0] dac;
   pcm_drive_s drive;
   int err_total, tests_run, n, m, r, s;
   localparam logic [3:0] rst_addr [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4,
      4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB};
   localparam logic [15:0] rst_val [11] = '{16'h0000, 16'h6A40, 16'h5500,
      16'h03E8, 16'h0AA0, 16'h0440, 16'h0FA0, 16'h0042, 16'h0000, 16'h0FA0,
      16'h0000};

   // 40 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   pcm_pwm dut (.clk_sys(clk_sys), .srst(srst), .ce(ce),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .peak_current_comparator(trip_in), .fault_pin(fault_pin),
      .drive(drive), .slope_threshold_dac(dac),
      .boost_high_switch_pin(bhi), .boost_low_switch_pin(blo));

   pcm_plant plant (.clk_sys(clk_sys), .srst(srst), .load_on(load_on),
      .force_trip(force_trip), .drive(drive), .dac(dac), .cmp_out(trip_in));

   // expected sawtooth code after one step, floored at zero
   function automatic logic [11:0] dac_exp(input int rv, input int sv);
      return (rv > sv) ? 12'(rv - sv) : 12'h000;
   endfunction : dac_exp
   // high-side ticks until the ramp meets the threshold, plus sync path
   function automatic int trip_len(input int d);
      return (d + 15) / 16 + 4;
   endfunction : trip_len
   function automatic logic in_rng(input int v, input int lo, input int hi);
      return (v >= lo) && (v <= hi);
   endfunction : in_rng

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   // read data stands only in the cycle after the strobe edge
   task automatic rd(input logic [3:0] a);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 rd_val = reg_rdata;
   endtask : rd
   // ticks until the chosen gate line reaches lvl, bounded
   task automatic wait_lvl(input bit sel_ls, input logic lvl, output int k);
      k = 0;
      while (((sel_ls ? drive.ls : drive.hs) !== lvl) && (k < 3000)) begin
         @(posedge clk_sys);
         #1 k++;
      end
      if (k >= 3000) begin
         err_total++;
         $display("Error t=%0t got %h exp %h", $time, k, 3000);
      end
   endtask : wait_lvl
   task automatic hi_ticks(input int span, output int k);
      k = 0;
      repeat (span) begin
         @(posedge clk_sys);
         #1 if (drive.hs === 1'b1) k++;
      end
   endtask : hi_ticks
   task automatic final_report();
      if (err_total == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : final_report

   // both gates on together would be shoot-through
   always @(negedge clk_sys) begin
      if (drive.hs === 1'b1) `CHK(drive.ls, 1'b0)
   end

   // watchdog, well beyond the roughly 13k ticks the sequence needs
   initial begin
      repeat (80000) @(posedge clk_sys);
      err_total++;
      $display("Error t=%0t got %h exp %h", $time, 0, 1);
      final_report();
   end

   initial begin
      ce = 1'b1;
      srst = 1'b1;
      {reg_wr, reg_rd, fault_pin, load_on, force_trip} = '0;
      reg_addr = '0;
      reg_wdata = '0;
      err_total = 0;
      tests_run = 0;
      void'($urandom(32'hd330));
      repeat (3) @(posedge clk_sys);
      srst <= 1'b0;
      // reset values, the unmapped word reads zero
      for (int i = 0; i < 11; i++) begin
         rd(rst_addr[i]);
         `CHK(rd_val, rst_val[i])
      end
      wr(4'h9, 16'h1234);
      rd(4'h9);
      `CHK(rd_val, 16'h0000)
      `CHK(dac, 12'hFA0)
      // shorter cycle; writes land at once with no update event
      wr(4'h1, 16'd999);
      wr(4'h2, 16'd600);
      wr(4'h3, 16'd50);
      wr(4'h4, 16'd40);
      wr(4'h5, 16'd16);
      rd(4'h2);
      `CHK(rd_val, 16'd600)
      // run with the boost pins held at static levels
      wr(4'h0, 16'h0003);
      repeat (5) @(posedge clk_sys);
      force_trip <= 1'b1; // pulse lies inside the blanking window
      repeat (10) @(posedge clk_sys);
      force_trip <= 1'b0;
      `CHK({bhi, blo}, 2'b10)
      wait_lvl(0, 1'b1, n);
      `CHK(n < 200, 1'b1)
      `CHK(dac, 12'd3934)
      wait_lvl(0, 1'b0, n);
      `CHK(in_rng(n, 504, 514), 1'b1)
      wait_lvl(1, 1'b1, n);
      `CHK(in_rng(n, 199, 205), 1'b1)
      wait_lvl(1, 1'b0, m);
      wait_lvl(0, 1'b1, n);
      `CHK(in_rng(n, 74, 79), 1'b1)
      wait_lvl(0, 1'b0, n);
      wait_lvl(0, 1'b1, m);
      `CHK(n + m, 1000)
      // period change mid-run shows in the very next cycles
      wr(4'h1, 16'd1199);
      wait_lvl(0, 1'b0, n);
      wait_lvl(0, 1'b1, n);
      wait_lvl(0, 1'b0, n);
      wait_lvl(0, 1'b1, m);
      `CHK(n + m, 1200)
      // clock enable low freezes everything: the high time stretches
      @(posedge clk_sys);
      ce <= 1'b0;
      repeat (100) @(posedge clk_sys);
      ce <= 1'b1;
      wait_lvl(0, 1'b0, n);
      `CHK(n, 507)
      // peak trips: one hand case with zero step, then random values
      load_on <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         r = (i == 0) ? 2000 : $urandom_range(2800, 1000);
         s = (i == 0) ? 0 : $urandom_range(200, 1);
         wait_lvl(0, 1'b0, n);
         wr(4'h6, 16'(r));
         wr(4'h7, 16'(s));
         wait_lvl(0, 1'b1, n);
         `CHK(dac, dac_exp(r, s))
         wait_lvl(0, 1'b0, n);
         m = trip_len(int'(dac_exp(r, s)));
         `CHK(in_rng(n, m - 2, m + 2), 1'b1)
         rd(4'h8);
         `CHK(rd_val[PCM_STAT_TRIP_SEEN], 1'b1)
         // comparator still high while the current decays: the trip wins
         wr(4'h8, 16'h0020);
         rd(4'h8);
         `CHK(rd_val[PCM_STAT_TRIP_SEEN], 1'b1)
         repeat (8) @(posedge clk_sys);
         wr(4'h8, 16'h0020);
         rd(4'h8);
         `CHK(rd_val[PCM_STAT_TRIP_SEEN], 1'b0)
      end
      // set and clear on the same tick: clear wins
      load_on <= 1'b0;
      wr(4'h2, 16'd16);
      wait_lvl(0, 1'b0, n);
      hi_ticks(1300, n);
      `CHK(n, 0)
      wr(4'h2, 16'd600);
      // fault drops the high side and keeps it down
      wait_lvl(0, 1'b1, n);
      @(posedge clk_sys);
      fault_pin <= 1'b1;
      wait_lvl(0, 1'b0, n);
      `CHK(n <= 5, 1'b1)
      hi_ticks(1300, n);
      `CHK(n, 0)
      @(posedge clk_sys);
      fault_pin <= 1'b0;
      wr(4'h0, 16'h0005);
      repeat (2) @(posedge clk_sys);
      `CHK({bhi, blo}, 2'b01)
      final_report();
   end
endmodule : tb_top
